// ---- rtl/status_event_groups.sv ----
/*
 * Operation and questionable status groups with condition, latched
 * event and enable registers, status byte, preset and clear-status.
 * Assumes one 40 MHz clock, asynchronous active-low reset, and an
 * AXI4-Lite master keeping to one write and one read at a time.
 */
// Summary of operation
// [R1] Enable mask reads leave the mask unchanged.
// [R2] Event bits record rising condition transitions.
// [R3] Event read returns bits then clears them.
// [R4] Host reads events before enabling requests.
// [R5] Preset zeroes both group enable masks.
// [R6] Preset leaves event registers untouched.
// [R7] Questionable mask 16 bits, summary status bit 3.
// [R8] Enable masks gate events into summaries.
// [R9] Questionable condition read is live, side-effect free.
// [R10] Operation event read returns set event bits.
// [R11] Clear-status clears events and error queue.
// [R12] Clear-status clears status byte bits 0-3,5,7.
// [R13] Clear-status leaves all enable masks alone.
// [R14] Clear-status cancels armed completion command/query.
// [R15] Operation mask 16 bits, summary status bit 7.
// [R16] Summary is OR of event AND enable.
// [R17] Event bit sets on rise, holds till cleared.
`timescale 1ns/1ps
`include "status_regs.svh"

module status_event_groups
	import status_pkg::*;
#(
	parameter int WIDTH = 16
)
(
	input wire logic CLOCK,
	input wire logic RESET_N,
	input wire logic [WIDTH-1:0] OPER_COND,
	input wire logic [WIDTH-1:0] QUES_COND,
	input wire logic [7:0] STD_EVENT_SET,
	input wire logic ERR_PUSH,
	input wire logic [2:0] DEV_STATUS_SET,
	input wire logic [7:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [7:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	output logic [7:0] STATUS_BYTE,
	output logic OPC_ARMED,
	output logic OPC_QUERY_PENDING,
	output logic IRQ
);

	// =================================================================
	// Write channel
	// =================================================================
	axi_word_t wr_r;
	logic aw_have_r;
	logic w_have_r;
	logic wr_fire;
	logic wr_hit;
	logic [3:0] wr_cmd;
	logic do_preset;
	logic do_clear;
	logic [WIDTH-1:0] wr_mask;

	assign AWREADY = !aw_have_r && !BVALID;
	assign WREADY = !w_have_r && !BVALID;
	assign wr_fire = aw_have_r && w_have_r && !BVALID;
	assign wr_mask = wr_r.data[WIDTH-1:0];
	assign wr_cmd = wr_fire && (wr_r.addr == `OFS_COMMAND) ?
		wr_r.data[3:0] : 4'h0;
	assign do_preset = wr_cmd[`CMD_PRESET];
	assign do_clear = wr_cmd[`CMD_CLEAR_STATUS];

	always_comb
	begin
		case (wr_r.addr)
			`OFS_OPER_ENABLE, `OFS_QUES_ENABLE, `OFS_COMMAND,
			`OFS_IRQ_CLEAR, `OFS_IRQ_ENABLE: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			wr_r <= '0;
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			BVALID <= 1'b0;
			BRESP <= `AXI_OKAY;
		end
		else
		begin
			if (AWVALID && AWREADY)
			begin
				wr_r.addr <= AWADDR;
				aw_have_r <= 1'b1;
			end
			if (WVALID && WREADY)
			begin
				wr_r.data <= WDATA;
				w_have_r <= 1'b1;
			end
			if (wr_fire)
			begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				BVALID <= 1'b1;
				BRESP <= wr_hit ? `AXI_OKAY : `AXI_DECERR;
			end
			else if (BVALID && BREADY)
				BVALID <= 1'b0;
		end
	end

	// =================================================================
	// Group registers
	// =================================================================
	group_t oper_r;
	group_t ques_r;
	logic [7:0] std_event_r;
	logic [7:0] err_count_r;
	logic [2:0] dev_r;
	logic oper_sum;
	logic ques_sum;
	logic rd_oper_event;
	logic rd_ques_event;
	logic rd_std_event;

	// Summaries are combinational so they follow event and mask at once.
	assign oper_sum = |(oper_r.event_bits & oper_r.enable); // [R16] [R8]
	assign ques_sum = |(ques_r.event_bits & ques_r.enable); // [R16] [R8]

	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			oper_r <= '0;
			ques_r <= '0;
		end
		else
		begin
			oper_r.cond <= OPER_COND;
			ques_r.cond <= QUES_COND;
			// A rise arriving in the clearing cycle still lands.
			oper_r.event_bits <= ((rd_oper_event || do_clear) ? '0 :
				oper_r.event_bits) | (OPER_COND & ~oper_r.cond); // [R2] [R17] [R3] [R11]
			ques_r.event_bits <= ((rd_ques_event || do_clear) ? '0 :
				ques_r.event_bits) | (QUES_COND & ~ques_r.cond); // [R2] [R17] [R3] [R11]
			if (do_preset)
			begin
				oper_r.enable <= `MASK_RESET; // [R5] [R6]
				ques_r.enable <= `MASK_RESET; // [R5]
			end
			else if (wr_fire && wr_r.addr == `OFS_OPER_ENABLE)
				oper_r.enable <= wr_mask; // [R15] [R13]
			else if (wr_fire && wr_r.addr == `OFS_QUES_ENABLE)
				ques_r.enable <= wr_mask; // [R7] [R13]
		end
	end

	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			std_event_r <= 8'h00;
			err_count_r <= 8'h00;
			dev_r <= 3'h0;
			OPC_ARMED <= 1'b0;
			OPC_QUERY_PENDING <= 1'b0;
		end
		else
		begin
			std_event_r <= ((rd_std_event || do_clear) ? 8'h00 :
				std_event_r) | STD_EVENT_SET; // [R11]
			if (do_clear)
				err_count_r <= ERR_PUSH ? 8'h01 : 8'h00; // [R11]
			else if (ERR_PUSH && err_count_r != 8'hFF)
				err_count_r <= err_count_r + 8'h01;
			dev_r <= (do_clear ? 3'h0 : dev_r) | DEV_STATUS_SET; // [R12]
			if (do_clear)
			begin
				OPC_ARMED <= 1'b0; // [R14]
				OPC_QUERY_PENDING <= 1'b0; // [R14]
			end
			else
			begin
				if (wr_cmd[`CMD_ARM_OPC])
					OPC_ARMED <= 1'b1;
				if (wr_cmd[`CMD_OPC_QUERY])
					OPC_QUERY_PENDING <= 1'b1;
			end
		end
	end

	always_comb
	begin
		STATUS_BYTE = 8'h00;
		STATUS_BYTE[2:0] = dev_r; // [R12]
		STATUS_BYTE[`SB_QUES_SUM] = ques_sum; // [R7]
		STATUS_BYTE[`SB_STD_SUM] = |std_event_r;
		STATUS_BYTE[`SB_OPER_SUM] = oper_sum; // [R15]
	end

	// =================================================================
	// Interrupts
	// =================================================================
	logic [`IRQ_BITS-1:0] irq_stat_r;
	logic [`IRQ_BITS-1:0] irq_en_r;
	logic [`IRQ_BITS-1:0] irq_evt;
	logic [`IRQ_BITS-1:0] irq_clr;

	assign irq_evt = {do_clear, do_preset, ques_sum, oper_sum};
	assign irq_clr = (wr_fire && wr_r.addr == `OFS_IRQ_CLEAR) ?
		wr_r.data[`IRQ_BITS-1:0] : '0;
	assign IRQ = |(irq_stat_r & irq_en_r);

	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			irq_stat_r <= '0;
			irq_en_r <= '0;
		end
		else
		begin
			irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_evt;
			if (wr_fire && wr_r.addr == `OFS_IRQ_ENABLE)
				irq_en_r <= wr_r.data[`IRQ_BITS-1:0];
		end
	end

	// =================================================================
	// Read channel
	// =================================================================
	rd_state_t rd_state_r;
	logic [31:0] rd_val;
	logic rd_ok;

	assign ARREADY = rd_state_r == RD_IDLE;
	assign RVALID = rd_state_r == RD_RESP;
	assign rd_oper_event = ARVALID && ARREADY &&
		ARADDR == `OFS_OPER_EVENT; // [R3] [R10]
	assign rd_ques_event = ARVALID && ARREADY &&
		ARADDR == `OFS_QUES_EVENT; // [R3]
	assign rd_std_event = ARVALID && ARREADY && ARADDR == `OFS_STD_EVENT;

	always_comb
	begin
		rd_val = 32'h0000_0000;
		rd_ok = 1'b1;
		case (ARADDR)
			`OFS_OPER_COND: rd_val[WIDTH-1:0] = OPER_COND;
			`OFS_OPER_EVENT: rd_val[WIDTH-1:0] = oper_r.event_bits; // [R10]
			`OFS_OPER_ENABLE: rd_val[WIDTH-1:0] = oper_r.enable; // [R1]
			`OFS_QUES_COND: rd_val[WIDTH-1:0] = QUES_COND; // [R9]
			`OFS_QUES_EVENT: rd_val[WIDTH-1:0] = ques_r.event_bits;
			`OFS_QUES_ENABLE: rd_val[WIDTH-1:0] = ques_r.enable; // [R1]
			`OFS_STD_EVENT: rd_val[7:0] = std_event_r;
			`OFS_STATUS_BYTE: rd_val[7:0] = STATUS_BYTE;
			`OFS_ERR_COUNT: rd_val[7:0] = err_count_r;
			`OFS_IRQ_STATUS: rd_val[`IRQ_BITS-1:0] = irq_stat_r;
			`OFS_IRQ_ENABLE: rd_val[`IRQ_BITS-1:0] = irq_en_r;
			`OFS_COMMAND: rd_val[3:2] = {OPC_QUERY_PENDING, OPC_ARMED};
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			rd_state_r <= RD_IDLE;
			RDATA <= 32'h0000_0000;
			RRESP <= `AXI_OKAY;
		end
		else
		begin
			case (rd_state_r)
				RD_IDLE:
					if (ARVALID)
					begin
						RDATA <= rd_val;
						RRESP <= rd_ok ? `AXI_OKAY : `AXI_DECERR;
						rd_state_r <= RD_RESP;
					end
				RD_RESP:
					if (RREADY)
						rd_state_r <= RD_IDLE;
				default:
					rd_state_r <= RD_IDLE;
			endcase
		end
	end

	// =================================================================
	// Assertions
	// =================================================================
	property p_evt_rise;
		@(posedge CLOCK) disable iff (!RESET_N)
		(OPER_COND[0] && !oper_r.cond[0]) |=> oper_r.event_bits[0];
	endproperty
	a_evt_rise: assert property (p_evt_rise) // [R2]
		else $error("event bit missed condition rise");

	property p_evt_hold;
		@(posedge CLOCK) disable iff (!RESET_N)
		(ques_r.event_bits[0] && !rd_ques_event && !do_clear)
			|=> ques_r.event_bits[0];
	endproperty
	a_evt_hold: assert property (p_evt_hold) // [R17]
		else $error("event bit dropped without clear");

	property p_read_clear;
		@(posedge CLOCK) disable iff (!RESET_N)
		(rd_oper_event && !(|(OPER_COND & ~oper_r.cond)))
			|=> oper_r.event_bits == '0 && RVALID;
	endproperty
	a_read_clear: assert property (p_read_clear) // [R3]
		else $error("event read did not clear");

	property p_read_value;
		@(posedge CLOCK) disable iff (!RESET_N)
		rd_oper_event |=> RDATA[15:0] == $past(oper_r.event_bits);
	endproperty
	a_read_value: assert property (p_read_value) // [R10]
		else $error("event read returned wrong value");

	property p_preset;
		@(posedge CLOCK) disable iff (!RESET_N)
		do_preset |=> oper_r.enable == '0 && ques_r.enable == '0
			&& !STATUS_BYTE[`SB_OPER_SUM] && !STATUS_BYTE[`SB_QUES_SUM];
	endproperty
	a_preset: assert property (p_preset) // [R5]
		else $error("preset left a mask set");

	property p_preset_keep;
		@(posedge CLOCK) disable iff (!RESET_N)
		(do_preset && !rd_oper_event && !do_clear)
			|=> (oper_r.event_bits & $past(oper_r.event_bits))
			== $past(oper_r.event_bits);
	endproperty
	a_preset_keep: assert property (p_preset_keep) // [R6]
		else $error("preset disturbed events");

	property p_summary;
		@(posedge CLOCK) disable iff (!RESET_N)
		STATUS_BYTE[`SB_QUES_SUM]
			== |(ques_r.event_bits & ques_r.enable);
	endproperty
	a_summary: assert property (p_summary) // [R16]
		else $error("questionable summary wrong");

	property p_clear;
		@(posedge CLOCK) disable iff (!RESET_N)
		(do_clear && DEV_STATUS_SET == 3'h0 && STD_EVENT_SET == 8'h00)
			|=> STATUS_BYTE[2:0] == 3'h0 && !STATUS_BYTE[`SB_STD_SUM]
			&& !OPC_ARMED && !OPC_QUERY_PENDING;
	endproperty
	a_clear: assert property (p_clear) // [R12]
		else $error("clear-status left bits set");

	property p_clear_masks;
		@(posedge CLOCK) disable iff (!RESET_N)
		(do_clear && !do_preset) |=> $stable(oper_r.enable)
			&& $stable(ques_r.enable);
	endproperty
	a_clear_masks: assert property (p_clear_masks) // [R13]
		else $error("clear-status changed a mask");

	property p_mask_read;
		@(posedge CLOCK) disable iff (!RESET_N)
		(ARVALID && ARREADY && ARADDR == `OFS_QUES_ENABLE && !wr_fire)
			|=> $stable(ques_r.enable);
	endproperty
	a_mask_read: assert property (p_mask_read) // [R1]
		else $error("mask read changed mask");

	c_irq: cover property (@(posedge CLOCK) disable iff (!RESET_N) IRQ);
	c_clear: cover property (@(posedge CLOCK) disable iff (!RESET_N)
		do_clear);
	c_sum: cover property (@(posedge CLOCK) disable iff (!RESET_N)
		STATUS_BYTE[`SB_OPER_SUM] ##1 do_preset);

endmodule : status_event_groups

// ---- rtl/status_regs.svh ----
/*
 * Register offsets, field positions, reset values and masks for the
 * instrument status block. Assumes a 32-bit AXI4-Lite register bus.
 */
`ifndef STATUS_REGS_SVH
`define STATUS_REGS_SVH

// =====================================================================
// Register byte offsets
// =====================================================================
`define OFS_OPER_COND 8'h00
`define OFS_OPER_EVENT 8'h04
`define OFS_OPER_ENABLE 8'h08
`define OFS_QUES_COND 8'h0C
`define OFS_QUES_EVENT 8'h10
`define OFS_QUES_ENABLE 8'h14
`define OFS_STD_EVENT 8'h18
`define OFS_STATUS_BYTE 8'h1C
`define OFS_COMMAND 8'h20
`define OFS_ERR_COUNT 8'h24
`define OFS_IRQ_STATUS 8'h28
`define OFS_IRQ_CLEAR 8'h2C
`define OFS_IRQ_ENABLE 8'h30

// =====================================================================
// Command register bits
// =====================================================================
`define CMD_PRESET 0
`define CMD_CLEAR_STATUS 1
`define CMD_ARM_OPC 2
`define CMD_OPC_QUERY 3

// =====================================================================
// Status byte bit positions
// =====================================================================
`define SB_QUES_SUM 3
`define SB_STD_SUM 5
`define SB_OPER_SUM 7

// =====================================================================
// Interrupt bits: 0 oper summary, 1 ques summary, 2 preset, 3 clear
// =====================================================================
`define IRQ_BITS 4
`define MASK_RESET 16'h0000
`define AXI_OKAY 2'h0
`define AXI_DECERR 2'h3

`endif

// ---- rtl/status_pkg.sv ----
/*
 * Types shared by the instrument status block.
 * Assumes the offsets in status_regs.svh.
 */
package status_pkg;

	typedef struct packed {
		logic [15:0] cond;
		logic [15:0] event_bits;
		logic [15:0] enable;
	} group_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] data;
	} axi_word_t;

	typedef enum logic [2:0] {
		RD_IDLE = 3'b001,
		RD_RESP = 3'b010,
		RD_HOLD = 3'b100
	} rd_state_t;

endpackage : status_pkg

// ---- verification/host_model.sv ----
/*
 * Host computer model: an AXI4-Lite master that issues register
 * queries and commands to the status block.
 * Assumes one clock shared with the block and one transfer at a time.
 */
`timescale 1ns/1ps

module host_model
(
	input wire logic CLOCK,
	output logic [7:0] AWADDR,
	output logic AWVALID,
	input wire logic AWREADY,
	output logic [31:0] WDATA,
	output logic [3:0] WSTRB,
	output logic WVALID,
	input wire logic WREADY,
	input wire logic [1:0] BRESP,
	input wire logic BVALID,
	output logic BREADY,
	output logic [7:0] ARADDR,
	output logic ARVALID,
	input wire logic ARREADY,
	input wire logic [31:0] RDATA,
	input wire logic [1:0] RRESP,
	input wire logic RVALID,
	output logic RREADY
);
	logic hung = 1'b0;

	initial
	begin
		{AWADDR, AWVALID, WDATA, WVALID, BREADY} = '0;
		{ARADDR, ARVALID, RREADY} = '0;
		WSTRB = 4'hF;
	end

	// =================================================================
	// Write: address and data offered together, released when taken.
	// =================================================================
	// Released payload is inverted so nothing can rely on a stale value.
	// Response ready stays high between calls, so a back-to-back call
	// never drives it twice in one time step.
	task wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		bit aw;
		bit w;
		aw = 0;
		w = 0;
		r = 2'bXX;
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		for (int n = 0; n < 64; n++)
		begin
			@(posedge CLOCK);
			if (aw && w)
			begin
				if (BVALID)
				begin
					r = BRESP;
					return;
				end
			end
			else
			begin
				if (!aw && AWREADY)
				begin
					aw = 1;
					AWVALID <= 1'b0;
					AWADDR <= ~a;
				end
				if (!w && WREADY)
				begin
					w = 1;
					WVALID <= 1'b0;
					WDATA <= ~d;
				end
			end
		end
		hung = 1'b1;
	endtask : wr

	// =================================================================
	// Read: address held until taken, then wait for the data beat.
	// =================================================================
	task rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		bit tk;
		tk = 0;
		r = 2'bXX;
		d = 'x;
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		for (int n = 0; n < 64; n++)
		begin
			@(posedge CLOCK);
			if (!tk && ARREADY)
			begin
				tk = 1;
				ARVALID <= 1'b0;
				ARADDR <= ~a;
			end
			else if (tk && RVALID)
			begin
				d = RDATA;
				r = RRESP;
				return;
			end
		end
		hung = 1'b1;
	endtask : rd

endmodule : host_model

// ---- verification/scpi_status_event_groups_bench.sv ----
/*
 * Self-checking bench for the status block: register sequences with
 * expected values, driven through the host model.
 * Assumes the offsets and command bits of status_regs.svh.
 */
`timescale 1ns/1ps
`include "status_regs.svh"

module scpi_status_event_groups_bench;
	logic CLOCK = 1'b0;
	logic RESET_N = 1'b0;
	logic [15:0] OPER_COND = '0;
	logic [15:0] QUES_COND = '0;
	logic [7:0] STD_EVENT_SET = '0;
	logic ERR_PUSH = 1'b0;
	logic [2:0] DEV_STATUS_SET = '0;
	logic [7:0] AWADDR, ARADDR, STATUS_BYTE;
	logic [31:0] WDATA, RDATA;
	logic [3:0] WSTRB;
	logic [1:0] BRESP, RRESP, exp_resp;
	logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
	logic ARVALID, ARREADY, RVALID, RREADY;
	logic OPC_ARMED, OPC_QUERY_PENDING, IRQ;
	int err_total = 0;
	int comparisons = 0;

	always #12.5 CLOCK = ~CLOCK;

	status_event_groups u_status_event_groups (.*);
	host_model u_host_model (.*);

	// =================================================================
	// Checking and bus helpers
	// =================================================================
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
		comparisons++;
		if (seen !== e)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, seen);
		end
	endtask : chk

	task test_done;
		if (err_total == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done

	task bus_end(input logic [1:0] r);
		chk("bus_hang", u_host_model.hung, 0);
		if (u_host_model.hung)
			test_done();
		chk("resp", r, exp_resp);
	endtask : bus_end

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		u_host_model.wr(a, d, r);
		bus_end(r);
	endtask : wr

	task rdchk(input logic [7:0] a, input logic [31:0] e);
		logic [1:0] r;
		logic [31:0] d;
		u_host_model.rd(a, d, r);
		bus_end(r);
		if (exp_resp === `AXI_OKAY)
			chk($sformatf("reg %h", a), d, e);
	endtask : rdchk

	task tick(input int n);
		repeat (n) @(posedge CLOCK);
	endtask : tick

	// =================================================================
	// Main sequence
	// =================================================================
	initial
	begin
		exp_resp = `AXI_OKAY;
		tick(3);
		RESET_N <= 1'b1;
		tick(1);
		wr(`OFS_COMMAND, 32'h1);
		rdchk(`OFS_IRQ_STATUS, 32'h4);
		chk("irq_masked", IRQ, 0);
		wr(`OFS_IRQ_ENABLE, 32'h4);
		tick(2);
		chk("irq_on", IRQ, 1);
		wr(`OFS_IRQ_CLEAR, 32'h4);
		tick(2);
		chk("irq_off", IRQ, 0);
		rdchk(`OFS_OPER_EVENT, 32'h0);
		rdchk(`OFS_OPER_ENABLE, 32'h0);
		wr(`OFS_OPER_ENABLE, 32'hFFFF);
		rdchk(`OFS_OPER_ENABLE, 32'hFFFF);
		rdchk(`OFS_OPER_ENABLE, 32'hFFFF);
		wr(`OFS_QUES_ENABLE, 32'hFFFF);
		rdchk(`OFS_QUES_ENABLE, 32'hFFFF);
		OPER_COND <= 16'h0100;
		tick(3);
		chk("oper_sum", STATUS_BYTE[`SB_OPER_SUM], 1);
		rdchk(`OFS_OPER_EVENT, 32'h0100);
		rdchk(`OFS_OPER_EVENT, 32'h0);
		chk("oper_sum_gone", STATUS_BYTE[`SB_OPER_SUM], 0);
		OPER_COND <= 16'h0;
		tick(3);
		rdchk(`OFS_OPER_EVENT, 32'h0);
		wr(`OFS_QUES_ENABLE, 32'h1);
		QUES_COND <= 16'h0010;
		tick(3);
		chk("ques_gated", STATUS_BYTE[`SB_QUES_SUM], 0);
		rdchk(`OFS_QUES_COND, 32'h0010);
		rdchk(`OFS_QUES_EVENT, 32'h0010);
		rdchk(`OFS_QUES_EVENT, 32'h0);
		QUES_COND <= 16'h0001;
		OPER_COND <= 16'h0001;
		tick(3);
		chk("ques_sum", STATUS_BYTE[`SB_QUES_SUM], 1);
		wr(`OFS_COMMAND, 32'h1);
		tick(2);
		chk("preset_sb", STATUS_BYTE & 8'h88, 0);
		rdchk(`OFS_OPER_ENABLE, 32'h0);
		rdchk(`OFS_QUES_ENABLE, 32'h0);
		rdchk(`OFS_OPER_EVENT, 32'h1);
		rdchk(`OFS_QUES_EVENT, 32'h1);
		OPER_COND <= 16'h0003;
		QUES_COND <= 16'h0003;
		STD_EVENT_SET <= 8'h04;
		DEV_STATUS_SET <= 3'h7;
		ERR_PUSH <= 1'b1;
		tick(1);
		STD_EVENT_SET <= 8'h00;
		DEV_STATUS_SET <= 3'h0;
		ERR_PUSH <= 1'b0;
		wr(`OFS_OPER_ENABLE, 32'h2);
		wr(`OFS_QUES_ENABLE, 32'h2);
		wr(`OFS_COMMAND, 32'hC);
		tick(2);
		chk("opc_armed_set", OPC_ARMED, 1);
		chk("opc_query_set", OPC_QUERY_PENDING, 1);
		rdchk(`OFS_COMMAND, 32'hC);
		chk("sb_before", STATUS_BYTE, 8'hAF);
		rdchk(`OFS_ERR_COUNT, 32'h1);
		wr(`OFS_COMMAND, 32'h2);
		tick(2);
		chk("sb_after", STATUS_BYTE, 8'h00);
		chk("opc_armed", OPC_ARMED, 0);
		chk("opc_query", OPC_QUERY_PENDING, 0);
		rdchk(`OFS_COMMAND, 32'h0);
		rdchk(`OFS_OPER_EVENT, 32'h0);
		rdchk(`OFS_QUES_EVENT, 32'h0);
		rdchk(`OFS_STD_EVENT, 32'h0);
		rdchk(`OFS_ERR_COUNT, 32'h0);
		rdchk(`OFS_OPER_ENABLE, 32'h2);
		rdchk(`OFS_QUES_ENABLE, 32'h2);
		rdchk(`OFS_IRQ_STATUS, 32'hF);
		exp_resp = `AXI_DECERR;
		rdchk(8'h3C, 32'h0);
		wr(8'h3C, 32'hFFFF);
		test_done();
	end

endmodule : scpi_status_event_groups_bench
